// ==== src/mirq_nand_tree.v ====
// nand chain over the monitored pins for board connectivity testing
`timescale 1ns/1ps
`default_nettype none
`include "mirq_regs.vh"

module mirq_nand_tree (
	// pins under test
	input wire [`MIRQ_TREE_N-1:0] pins,
	// chain result
	output wire result
);

	wire [`MIRQ_TREE_N:0] stage;

	// chain seeded high so a single pin toggle flips the result
	assign stage[0] = 1'b1;
	genvar i;
	generate
		for (i = 0; i < `MIRQ_TREE_N; i = i + 1) begin : g_stage
			assign stage[i+1] = ~(stage[i] & pins[i]);
		end
	endgenerate

	assign result = stage[`MIRQ_TREE_N];

endmodule
`default_nettype wire

// ==== src/mirq_regs.vh ====
// constants and register map of the monitor interrupt and test pin block
// What this block does
// - active-low external interrupt input is forwarded to the interrupt output
// - interrupt output asserts when external, board alert or chassis source signals
// - interrupt output is push-pull, selectable active-high or active-low
// - high chassis input is latched and held after the input falls
// - active-low test input starts connectivity test and resets control, status, enable, chassis latch and reset timer; address straps hold
// - during test the lowest address pin becomes the test chain output
// - slave address low bits come from three straps, bit 0 least significant
// - active-low open-drain general-purpose output for power or fan control
// - shared open-drain output gives master reset or temperature alarm
`ifndef MIRQ_REGS_VH
`define MIRQ_REGS_VH

// byte offsets on the register bus
`define MIRQ_CTRL_OFS 12'h000
`define MIRQ_STAT_OFS 12'h004
`define MIRQ_CLR_OFS 12'h008
`define MIRQ_IEN_OFS 12'h00c
`define MIRQ_PINS_OFS 12'h010

// control fields
`define MIRQ_CTRL_POL 0
`define MIRQ_CTRL_GPO 1
`define MIRQ_CTRL_RSTSEL 2
`define MIRQ_CTRL_RSTGO 3
`define MIRQ_CTRL_EXTEN 4
`define MIRQ_CTRL_BTIEN 5
`define MIRQ_CTRL_CHEN 6
`define MIRQ_CTRL_W 7
`define MIRQ_CTRL_RST 7'h70

// status, clear and enable fields
`define MIRQ_EV_EXT 0
`define MIRQ_EV_BTI 1
`define MIRQ_EV_CHS 2
`define MIRQ_EV_OT 3
`define MIRQ_EV_W 4
`define MIRQ_STAT_RST 4'h0
`define MIRQ_IEN_RST 4'h0

// pins register fields
`define MIRQ_PINS_ADDR 0
`define MIRQ_PINS_TEST 3
`define MIRQ_PINS_CHL 4

// tree width: number of pins chained in the connectivity test
`define MIRQ_TREE_N 6

// master reset pulse timing
`define MIRQ_CLK_NS 40
`define MIRQ_RST_PULSE_NS 20000
`define MIRQ_RST_CYC (`MIRQ_RST_PULSE_NS / `MIRQ_CLK_NS)
`define MIRQ_RST_CW 10

`endif

// ==== src/mirq_top.v ====
// interrupt aggregation, general outputs, address straps and test mode of the monitor
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mirq_regs.vh"

module mirq_top (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// interrupt sources
	input wire ext_int_n,
	input wire board_temp_alert_n,
	input wire chassis_intrusion_in,
	input wire overtemp_alarm,
	// interrupt outputs
	output reg int_out,
	output reg irq,
	// connectivity test and address straps
	input wire connectivity_test_n,
	input wire addr_bit0_test_out_i,
	output reg addr_bit0_test_out_o,
	output reg addr_bit0_test_out_oe,
	input wire addr_bit1,
	input wire addr_bit2,
	output reg [2:0] slave_addr_low,
	// open-drain outputs
	output reg power_ctrl_out_n_o,
	output reg power_ctrl_out_n_oe,
	output reg reset_or_overtemp_out_o,
	output reg reset_or_overtemp_out_oe
);

	// state
	reg [`MIRQ_CTRL_W-1:0] ctrl_r;
	reg [`MIRQ_EV_W-1:0] stat_r;
	reg [`MIRQ_EV_W-1:0] stat_nxt;
	reg [`MIRQ_EV_W-1:0] ien_r;
	reg chassis_latch_r;
	reg [`MIRQ_RST_CW-1:0] rst_cnt_r;
	reg rst_active_r;
	reg [31:0] rdata_nxt;
	reg addr_ok;

	wire test_active;
	wire wr_en;
	wire setup;
	wire clr_wr;
	wire ctrl_wr;
	wire ien_wr;
	wire [`MIRQ_EV_W-1:0] ev_now;
	wire [`MIRQ_EV_W-1:0] clr_bits;
	wire src_any;
	wire tree_out;
	wire [`MIRQ_TREE_N-1:0] tree_pins;
	wire [`MIRQ_RST_CW-1:0] rst_len;
	wire [31:0] rst_cyc_full;

	// test mode is the low level of the test pin
	assign test_active = ~connectivity_test_n;

	// bus phases: one wait-free access, write commits on the handshake edge
	assign setup = psel & ~penable;
	assign wr_en = psel & penable & pready & pwrite;
	assign ctrl_wr = wr_en & (paddr == `MIRQ_CTRL_OFS);
	assign clr_wr = wr_en & (paddr == `MIRQ_CLR_OFS);
	assign ien_wr = wr_en & (paddr == `MIRQ_IEN_OFS);
	assign clr_bits = clr_wr ? pwdata[`MIRQ_EV_W-1:0] : {`MIRQ_EV_W{1'b0}};
	// pulse length is below 1024 cycles, so the counter width holds it
	assign rst_cyc_full = `MIRQ_RST_CYC;
	assign rst_len = rst_cyc_full[`MIRQ_RST_CW-1:0];

	// current event levels feeding the sticky status
	assign ev_now[`MIRQ_EV_EXT] = ~ext_int_n;
	assign ev_now[`MIRQ_EV_BTI] = ~board_temp_alert_n;
	// latch held unless cleared now; a fresh high still sets, so one clear suffices
	assign ev_now[`MIRQ_EV_CHS] = (chassis_latch_r & ~clr_bits[`MIRQ_EV_CHS]) | chassis_intrusion_in;
	assign ev_now[`MIRQ_EV_OT] = overtemp_alarm;

	// any enabled source drives the pin; chassis uses its latch, not the raw input
	assign src_any = (ctrl_r[`MIRQ_CTRL_EXTEN] & ~ext_int_n)
		| (ctrl_r[`MIRQ_CTRL_BTIEN] & ~board_temp_alert_n)
		| (ctrl_r[`MIRQ_CTRL_CHEN] & chassis_latch_r);

	// pins chained in the connectivity test; address bit 0 is excluded, it is the output
	assign tree_pins = {addr_bit2, addr_bit1, overtemp_alarm, chassis_intrusion_in,
		board_temp_alert_n, ext_int_n};

	mirq_nand_tree u_tree (
		.pins(tree_pins),
		.result(tree_out)
	);

	// address decode for reads and the error answer
	always @* begin
		rdata_nxt = 32'h0000_0000;
		addr_ok = 1'b1;
		if (paddr == `MIRQ_CTRL_OFS) begin
			rdata_nxt[`MIRQ_CTRL_W-1:0] = ctrl_r;
		end else if (paddr == `MIRQ_STAT_OFS) begin
			rdata_nxt[`MIRQ_EV_W-1:0] = stat_r;
		end else if (paddr == `MIRQ_CLR_OFS) begin
			rdata_nxt = 32'h0000_0000; // write-only, reads zero
		end else if (paddr == `MIRQ_IEN_OFS) begin
			rdata_nxt[`MIRQ_EV_W-1:0] = ien_r;
		end else if (paddr == `MIRQ_PINS_OFS) begin
			rdata_nxt[`MIRQ_PINS_ADDR+2:`MIRQ_PINS_ADDR] = slave_addr_low;
			rdata_nxt[`MIRQ_PINS_TEST] = test_active;
			rdata_nxt[`MIRQ_PINS_CHL] = chassis_latch_r;
		end else begin
			addr_ok = 1'b0;
		end
	end

	// sticky status: a set in the same cycle as its clear is kept
	always @* begin
		stat_nxt = (stat_r & ~clr_bits) | ev_now;
	end

	// bus answer registered in the setup cycle, so every access ends after one access cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~addr_ok;
			if (setup && !pwrite) begin
				prdata <= rdata_nxt;
			end else if (!(psel && penable)) begin
				prdata <= 32'h0000_0000; // no stale read data under a following write
			end
		end
	end

	// control register; the reset-go bit is a pulse, never stored
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `MIRQ_CTRL_RST;
		end else if (test_active) begin
			ctrl_r <= `MIRQ_CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_r <= pwdata[`MIRQ_CTRL_W-1:0];
			ctrl_r[`MIRQ_CTRL_RSTGO] <= 1'b0;
		end
	end

	// status and interrupt enable
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= `MIRQ_STAT_RST;
			ien_r <= `MIRQ_IEN_RST;
		end else if (test_active) begin
			stat_r <= `MIRQ_STAT_RST;
			ien_r <= `MIRQ_IEN_RST;
		end else begin
			stat_r <= stat_nxt;
			if (ien_wr) begin
				ien_r <= pwdata[`MIRQ_EV_W-1:0];
			end
		end
	end

	// chassis latch holds after the input falls; a new high beats a clear
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chassis_latch_r <= 1'b0;
		end else if (test_active) begin
			chassis_latch_r <= 1'b0;
		end else if (chassis_intrusion_in) begin
			chassis_latch_r <= 1'b1;
		end else if (clr_bits[`MIRQ_EV_CHS]) begin
			chassis_latch_r <= 1'b0;
		end
	end

	// master reset pulse timer; a rewrite during the pulse restarts it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_cnt_r <= {`MIRQ_RST_CW{1'b0}};
			rst_active_r <= 1'b0;
		end else if (test_active) begin
			rst_cnt_r <= {`MIRQ_RST_CW{1'b0}};
			rst_active_r <= 1'b0;
		end else if (ctrl_wr && pwdata[`MIRQ_CTRL_RSTGO]) begin
			rst_cnt_r <= rst_len - 1'b1;
			rst_active_r <= 1'b1;
		end else if (rst_cnt_r != {`MIRQ_RST_CW{1'b0}}) begin
			rst_cnt_r <= rst_cnt_r - 1'b1;
		end else begin
			rst_active_r <= 1'b0;
		end
	end

	// interrupt pin: polarity bit set gives active-high form, clear gives active-low
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			int_out <= 1'b1;
			irq <= 1'b0;
		end else if (test_active) begin
			int_out <= 1'b1; // inactive in the reset default active-low form
			irq <= 1'b0;
		end else begin
			int_out <= ctrl_r[`MIRQ_CTRL_POL] ? src_any : ~src_any;
			irq <= |(stat_nxt & ien_r);
		end
	end

	// straps sampled only outside test, since bit 0 is then our own output
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slave_addr_low <= 3'h0;
		end else if (!test_active && !addr_bit0_test_out_oe) begin
			slave_addr_low <= {addr_bit2, addr_bit1, addr_bit0_test_out_i};
		end
	end

	// address bit 0 turns into the chain output during test
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_bit0_test_out_o <= 1'b0;
			addr_bit0_test_out_oe <= 1'b0;
		end else begin
			addr_bit0_test_out_o <= tree_out;
			addr_bit0_test_out_oe <= test_active;
		end
	end

	// open-drain outputs only ever pull low; enable high means pulling
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_ctrl_out_n_o <= 1'b0;
			power_ctrl_out_n_oe <= 1'b0;
			reset_or_overtemp_out_o <= 1'b0;
			reset_or_overtemp_out_oe <= 1'b0;
		end else begin
			power_ctrl_out_n_o <= 1'b0;
			power_ctrl_out_n_oe <= ctrl_r[`MIRQ_CTRL_GPO] & ~test_active;
			reset_or_overtemp_out_o <= 1'b0;
			// select bit picks the master reset pulse, else the temperature alarm
			reset_or_overtemp_out_oe <= ~test_active & (ctrl_r[`MIRQ_CTRL_RSTSEL] ?
				rst_active_r : overtemp_alarm);
		end
	end

endmodule
`default_nettype wire

// ==== verif/mirq_chk.sv ====
// assertion checker for the monitor interrupt and test pin block
`timescale 1ns/1ps
`default_nettype none
`include "mirq_regs.vh"
module mirq_chk (
	// bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// pins
	input wire logic ext_int_n,
	input wire logic board_temp_alert_n,
	input wire logic chassis_intrusion_in,
	input wire logic overtemp_alarm,
	input wire logic int_out,
	input wire logic irq,
	input wire logic connectivity_test_n,
	input wire logic addr_bit0_test_out_i,
	input wire logic addr_bit0_test_out_o,
	input wire logic addr_bit0_test_out_oe,
	input wire logic addr_bit1,
	input wire logic addr_bit2,
	input wire logic [2:0] slave_addr_low,
	input wire logic reset_or_overtemp_out_oe
);
	logic [6:0] ctrl_r;
	logic [9:0] run_r;
	wire wr = psel && penable && pready && pwrite;
	wire go = presetn && connectivity_test_n;
	wire chain = ~(addr_bit2 & ~(addr_bit1 & ~(overtemp_alarm & ~(chassis_intrusion_in & ~(board_temp_alert_n & ~ext_int_n)))));
	// control mirror and pulse length; test mode restores control as reset does
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_r <= `MIRQ_CTRL_RST;
			run_r <= 10'h000;
		end else begin
			run_r <= reset_or_overtemp_out_oe ? run_r + 10'h001 : 10'h000;
			if (!connectivity_test_n)
				ctrl_r <= `MIRQ_CTRL_RST;
			else if (wr && paddr == `MIRQ_CTRL_OFS)
				ctrl_r <= pwdata[6:0];
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_tst2; !connectivity_test_n ##1 !connectivity_test_n; endsequence
	sequence s_chs; go && chassis_intrusion_in && ctrl_r[6] && !wr ##1 (go && !chassis_intrusion_in && !wr)[*2]; endsequence
	property p_ext; go && !ext_int_n && ctrl_r[4] |=> int_out == $past(ctrl_r[0]); endproperty
	property p_idle; go && ctrl_r[6:4] == 3'b000 |=> int_out == !$past(ctrl_r[0]); endproperty
	property p_bti; go && !board_temp_alert_n && ctrl_r[5] |=> int_out == $past(ctrl_r[0]); endproperty
	property p_chs; s_chs |=> int_out == ctrl_r[0]; endproperty
	property p_quiet; !connectivity_test_n |=> int_out && !irq && !reset_or_overtemp_out_oe; endproperty
	property p_tout; s_tst2 |-> addr_bit0_test_out_oe && addr_bit0_test_out_o == $past(chain); endproperty
	property p_addr; go && !addr_bit0_test_out_oe ##1 go |-> slave_addr_low == $past({addr_bit2, addr_bit1, addr_bit0_test_out_i}); endproperty
	property p_rlen; $fell(reset_or_overtemp_out_oe) && ctrl_r[2] |-> run_r == `MIRQ_RST_CYC; endproperty
	a_ext: assert property (p_ext) else $error("int_out ignores external input");
	a_idle: assert property (p_idle) else $error("int_out active with all sources off");
	a_bti: assert property (p_bti) else $error("int_out ignores board alert");
	a_chs: assert property (p_chs) else $error("chassis event not held");
	a_quiet: assert property (p_quiet) else $error("outputs busy in test mode");
	a_tout: assert property (p_tout) else $error("test chain output wrong");
	a_addr: assert property (p_addr) else $error("slave address bits wrong");
	a_rlen: assert property (p_rlen) else $error("reset pulse length wrong");
endmodule
bind mirq_top mirq_chk u_chk (.*);
`default_nettype wire

// ==== verif/mirq_sensor.sv ====
// temperature sensor shutdown output driving the board alert line
`timescale 1ns/1ps
`default_nettype none
module mirq_sensor (
	// clock
	input wire logic pclk,
	// sensor state and alert line
	input wire logic hot,
	output logic alert_n
);
	// open drain with pull-up, so a released output reads high
	initial alert_n = 1'b1;
	always @(posedge pclk) alert_n <= !hot;
endmodule
`default_nettype wire

// ==== verif/monitor_irq_and_test_pins_tb.sv ====
// self-checking bench for the monitor interrupt and test pin block
`timescale 1ns/1ps
`default_nettype none
`include "mirq_regs.vh"
module monitor_irq_and_test_pins_tb;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, hot = 1'b0, a0 = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic ext_int_n = 1'b1, chassis_intrusion_in = 1'b0, overtemp_alarm = 1'b0, connectivity_test_n = 1'b1;
	logic addr_bit1 = 1'b0, addr_bit2 = 1'b0, pready, pslverr, int_out, irq, board_temp_alert_n;
	logic addr_bit0_test_out_o, addr_bit0_test_out_oe, power_ctrl_out_n_o, power_ctrl_out_n_oe;
	logic reset_or_overtemp_out_o, reset_or_overtemp_out_oe;
	logic [2:0] slave_addr_low;
	int errors = 0, samples_checked = 0, cyc = 0;
	// the pin carries the chain result whenever the block drives it
	wire addr_bit0_test_out_i = addr_bit0_test_out_oe ? addr_bit0_test_out_o : a0;
	mirq_top dut (.*);
	mirq_sensor u_sens (.pclk(pclk), .hot(hot), .alert_n(board_temp_alert_n));
	always #20 pclk = ~pclk;
	// hang guard, well above the pulse wait
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			errors++;
			complete_run();
		end
	end
	task automatic complete_run();
		$display("checks %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	// one apb transfer, then one idle edge so the next setup never collides
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk("read data", e, rd);
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(`MIRQ_CTRL_OFS, 32'h70);
		apb(1'b0, 12'h100, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, err});
		apb(1'b1, `MIRQ_IEN_OFS, 32'h1);
		ext_int_n <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("int_out", 32'h0, {31'h0, int_out});
		chk("irq", 32'h1, {31'h0, irq});
		ext_int_n <= 1'b1;
		apb(1'b1, `MIRQ_CLR_OFS, 32'h1);
		hot <= 1'b1;
		repeat (4) @(posedge pclk);
		chk("int_out", 32'h0, {31'h0, int_out});
		chk("irq masked", 32'h0, {31'h0, irq});
		rchk(`MIRQ_STAT_OFS, 32'h2);
		hot <= 1'b0;
		apb(1'b1, `MIRQ_CTRL_OFS, 32'h1);
		ext_int_n <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("int_out off", 32'h0, {31'h0, int_out});
		ext_int_n <= 1'b1;
		apb(1'b1, `MIRQ_CLR_OFS, 32'hf);
		apb(1'b1, `MIRQ_CTRL_OFS, 32'h71);
		chassis_intrusion_in <= 1'b1;
		@(posedge pclk);
		chassis_intrusion_in <= 1'b0;
		repeat (4) @(posedge pclk);
		chk("int_out high", 32'h1, {31'h0, int_out});
		rchk(`MIRQ_STAT_OFS, 32'h4);
		apb(1'b1, `MIRQ_CLR_OFS, 32'h4);
		@(posedge pclk);
		chk("int_out cleared", 32'h0, {31'h0, int_out});
		rchk(`MIRQ_STAT_OFS, 32'h0);
		a0 <= 1'b1;
		addr_bit2 <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("slave address", 32'h5, {29'h0, slave_addr_low});
		rchk(`MIRQ_PINS_OFS, 32'h5);
		addr_bit1 <= 1'b1;
		apb(1'b1, `MIRQ_CTRL_OFS, 32'h73);
		// the pin register follows control one edge after the write lands
		@(posedge pclk);
		chk("power pin", 32'h2, {30'h0, power_ctrl_out_n_oe, power_ctrl_out_n_o});
		apb(1'b1, `MIRQ_CTRL_OFS, 32'h7c);
		repeat (3) @(posedge pclk);
		chk("reset pin", 32'h2, {30'h0, reset_or_overtemp_out_oe, reset_or_overtemp_out_o});
		repeat (500) @(posedge pclk);
		chk("reset pin end", 32'h0, {31'h0, reset_or_overtemp_out_oe});
		connectivity_test_n <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("test pins", 32'h7, {29'h0, addr_bit0_test_out_oe, addr_bit0_test_out_o, int_out});
		connectivity_test_n <= 1'b1;
		@(posedge pclk);
		rchk(`MIRQ_CTRL_OFS, 32'h70);
		// control back at reset value, so the shared pin now carries the alarm
		overtemp_alarm <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("alarm pin", 32'h2, {30'h0, reset_or_overtemp_out_oe, reset_or_overtemp_out_o});
		rchk(`MIRQ_STAT_OFS, 32'h8);
		overtemp_alarm <= 1'b0;
		complete_run();
	end
endmodule
`default_nettype wire
